/* File: core/dls_serializer_top.sv */
// Display link serializer: pixel capture, word crossing, lane shifting
//
// Contract
// - Wide build captures 28 bits onto four lanes
// - Forwarded clock rides on its own extra lane
// - Each lane sends seven bits per period
// - Narrow build captures 21 bits onto three lanes
// - Word holds colour, line, frame, enable bits
// - Capture edge chosen by a static select
// - Select high rising edge, low falling edge
// - Serial format identical for either capture edge
// - Bit 0 starts period, bit 6 last
// - Power-down low disables every lane driver
// - Drivers off within 100 ns of power-down
// - No valid output before 10 ms lock wait
`timescale 1ns/100ps
module dls_serializer_top
    import dls_pkg::*;
#(
    parameter  int LANES            = WIDE_LANES,
    parameter  int LOCK_WAIT_CYCLES = PLL_LOCK_WAIT_CYC,
    // Colour width follows the lane count; the ports need it early
    localparam int COLOR_W          = (LANES == WIDE_LANES) ? WIDE_COLOR_W
                                                            : NARROW_COLOR_W
)
(
    // Pixel clock (from the controller) and reset
    input  wire logic                clk_sys_in,
    input  wire logic                nrst_in,
    // Seven-times lane bit clock
    input  wire logic                bit_clk_in,
    // Parallel pixel word
    input  wire logic [COLOR_W-1:0]  colour_in,
    input  wire logic                line_sync_in,
    input  wire logic                frame_sync_in,
    input  wire logic                data_valid_enable_in,
    input  wire logic                spare_in,
    // Static configuration pins
    input  wire logic                strobe_edge_select_in,
    input  wire logic                power_down_n_in,
    // Data lanes
    output logic      [LANES-1:0]    serial_data_lane_out,
    output logic      [LANES-1:0]    serial_data_lane_oe_out,
    // Forwarded clock lane
    output logic                     forwarded_lane_clock_out,
    output logic                     forwarded_lane_clock_oe_out,
    // Status
    output logic                     link_ready_out
);

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int FULL_W  = COLOR_W + CTRL_BITS + 1;  // With spare bit
    localparam int WORD_W  = LANES * SLOTS;            // 28 or 21

    // Spare bit on top, then enable, frame sync, line sync, colour
    logic [FULL_W-1:0] word_full;
    logic [WORD_W-1:0] word_in;

    // Narrow build drops the spare bit by the slice below
    assign word_full = {spare_in, data_valid_enable_in, frame_sync_in,
                        line_sync_in, colour_in};
    assign word_in   = word_full[WORD_W-1:0];

    // ------------------------------------------------------------------
    // Pin synchronisers in the pixel domain
    // ------------------------------------------------------------------
    logic edge_sel_sync;   // Filtered strobe edge select
    logic pwr_on_sys;      // Filtered power-down, high means running
    logic ack_sys;         // Link acknowledge toggle, filtered

    dls_sync #(.W(1), .RST_VAL(1'h1)) u_sync_edge
    (
        .clk_in  (clk_sys_in),
        .nrst_in (nrst_in),
        .d_in    (strobe_edge_select_in),
        .q_out   (edge_sel_sync)
    );

    dls_sync #(.W(1), .RST_VAL(1'h0)) u_sync_pwr_sys
    (
        .clk_in  (clk_sys_in),
        .nrst_in (nrst_in),
        .d_in    (power_down_n_in),
        .q_out   (pwr_on_sys)
    );

    // ------------------------------------------------------------------
    // Capture on either pixel clock edge
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] fall_cap_reg;   // Word taken on the falling edge
    logic [WORD_W-1:0] cap_reg;        // Word chosen for this period
    logic [WORD_W-1:0] cap_next;

    // Falling-edge sample, used only when the select is low
    always_ff @(negedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fall_cap_reg <= '0;
        end
        else
        begin
            fall_cap_reg <= word_in;
        end
    end

    // Both paths land in one register, so the lanes never see the choice
    always_comb
    begin
        if (edge_sel_sync)
        begin
            cap_next = word_in;
        end
        else
        begin
            cap_next = fall_cap_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cap_reg <= '0;
        end
        else
        begin
            cap_reg <= cap_next;
        end
    end

    // ------------------------------------------------------------------
    // Lock wait and word hand-off, pixel domain
    // ------------------------------------------------------------------
    dls_state_t             state_reg;
    dls_state_t             state_next;
    logic [LOCK_CNT_W-1:0]  lock_cnt_reg;   // Cycles waited for lock
    logic [LOCK_CNT_W-1:0]  lock_cnt_next;
    logic [WORD_W-1:0]      hold_reg;       // Word offered to the link
    logic [WORD_W-1:0]      hold_next;
    logic                   req_reg;        // Offer toggle
    logic                   req_next;
    logic                   ready_reg;      // Link valid after lock
    logic                   ready_next;

    // Hold stays still from offer to acknowledge, unless power-down clears it, so the link may copy it
    always_comb
    begin
        state_next    = state_reg;
        lock_cnt_next = lock_cnt_reg;
        hold_next     = hold_reg;
        req_next      = req_reg;
        ready_next    = 1'h0;
        case (state_reg)
            DLS_OFF:
            begin
                lock_cnt_next = '0;
                if (pwr_on_sys)
                begin
                    state_next = DLS_LOCK_WAIT;
                end
            end
            DLS_LOCK_WAIT:
            begin
                // Nothing is offered until the lock time has run out
                if (!pwr_on_sys)
                begin
                    state_next = DLS_OFF;
                end
                else if (lock_cnt_reg ==
                         LOCK_CNT_W'(LOCK_WAIT_CYCLES - 1))
                begin
                    state_next = DLS_RUN;
                end
                else
                begin
                    lock_cnt_next = lock_cnt_reg + 1'h1;
                end
            end
            DLS_RUN:
            begin
                ready_next = pwr_on_sys;
                if (!pwr_on_sys)
                begin
                    state_next = DLS_OFF;
                    hold_next  = '0;
                end
                else if (req_reg == ack_sys)
                begin
                    // Latest captured word; older ones are overwritten
                    hold_next = cap_reg;
                    req_next  = ~req_reg;
                end
            end
            default:
            begin
                state_next = DLS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg    <= DLS_OFF;
            lock_cnt_reg <= '0;
            hold_reg     <= '0;
            req_reg      <= 1'h0;
            ready_reg    <= 1'h0;
        end
        else
        begin
            state_reg    <= state_next;
            lock_cnt_reg <= lock_cnt_next;
            hold_reg     <= hold_next;
            req_reg      <= req_next;
            ready_reg    <= ready_next;
        end
    end

    assign link_ready_out = ready_reg;

    // ------------------------------------------------------------------
    // Link domain synchronisers
    // ------------------------------------------------------------------
    logic pwr_on_link;   // Filtered power-down in the lane domain
    logic req_link;      // Offer toggle seen by the lane domain

    dls_sync #(.W(1), .RST_VAL(1'h0)) u_sync_pwr_link
    (
        .clk_in  (bit_clk_in),
        .nrst_in (nrst_in),
        .d_in    (power_down_n_in),
        .q_out   (pwr_on_link)
    );

    dls_sync #(.W(1), .RST_VAL(1'h0)) u_sync_req
    (
        .clk_in  (bit_clk_in),
        .nrst_in (nrst_in),
        .d_in    (req_reg),
        .q_out   (req_link)
    );

    // ------------------------------------------------------------------
    // Link domain: slot count, word staging, enables
    // ------------------------------------------------------------------
    logic [SLOT_W-1:0] slot_reg;      // Slot on the line next
    logic [SLOT_W-1:0] slot_next;
    logic              ack_reg;       // Returned toggle
    logic              ack_next;
    logic [WORD_W-1:0] stage_reg;     // Word waiting for a period start
    logic [WORD_W-1:0] stage_next;
    logic              oe_reg;        // Driver enable for every lane
    logic              oe_next;
    logic              fwd_reg;       // Forwarded clock bit
    logic              fwd_next;
    logic              load;          // Period start strobe

    assign load = (slot_reg == SLOT_FIRST);

    // Copy the held word once the offer is seen, then hand back the toggle
    always_comb
    begin
        slot_next  = (slot_reg == SLOT_LAST) ? SLOT_FIRST
                                             : slot_reg + 1'h1;
        stage_next = stage_reg;
        ack_next   = ack_reg;
        if (req_link != ack_reg)
        begin
            stage_next = hold_reg;
            ack_next   = req_link;
        end
        // Turned off at the first filtered edge, well under 100 ns
        oe_next  = pwr_on_link;
        fwd_next = pwr_on_link & FWD_CLK_PATTERN[slot_reg];
    end

    always_ff @(posedge bit_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            slot_reg  <= SLOT_FIRST;
            ack_reg   <= 1'h0;
            stage_reg <= '0;
            oe_reg    <= 1'h0;
            fwd_reg   <= 1'h0;
        end
        else
        begin
            slot_reg  <= slot_next;
            ack_reg   <= ack_next;
            stage_reg <= stage_next;
            oe_reg    <= oe_next;
            fwd_reg   <= fwd_next;
        end
    end

    // Acknowledge back to the pixel domain
    dls_sync #(.W(1), .RST_VAL(1'h0)) u_sync_ack
    (
        .clk_in  (clk_sys_in),
        .nrst_in (nrst_in),
        .d_in    (ack_reg),
        .q_out   (ack_sys)
    );

    // ------------------------------------------------------------------
    // Lane shifters: lane n carries word bits 7n up to 7n+6
    // ------------------------------------------------------------------
    for (genvar ln = 0; ln < LANES; ln++)
    begin : g_lane
        dls_lane_ser u_lane
        (
            .clk_in    (bit_clk_in),
            .nrst_in   (nrst_in),
            .load_in   (load),
            .slots_in  (stage_reg[ln*SLOTS +: SLOTS]),
            .enable_in (pwr_on_link),
            .bit_out   (serial_data_lane_out[ln])
        );
    end

    // Enables fan out from one flop to every data lane and the clock lane
    assign serial_data_lane_oe_out     = {LANES{oe_reg}};
    assign forwarded_lane_clock_out    = fwd_reg;
    assign forwarded_lane_clock_oe_out = oe_reg;

endmodule : dls_serializer_top

/* File: core/dls_pkg.sv */
// Shared constants for the display link serializer
package dls_pkg;

    // ------------------------------------------------------------------
    // Lane and word geometry
    // ------------------------------------------------------------------
    localparam int SLOTS          = 7;  // Serial bits per lane per period
    localparam int SLOT_W         = 3;  // Width of the slot counter
    localparam int WIDE_LANES     = 4;  // Data lanes, wide variant
    localparam int NARROW_LANES   = 3;  // Data lanes, narrow variant
    localparam int WIDE_COLOR_W   = 24; // Colour bits, wide variant
    localparam int NARROW_COLOR_W = 18; // Colour bits, narrow variant
    localparam int CTRL_BITS      = 3;  // Line sync, frame sync, enable
    localparam int SYNC_STAGES    = 3;  // Shift stages in each synchroniser, ahead of its filter flop

    // Slot counter values of the first and last bits of a period
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h6;

    // Forwarded clock shape, slot 0 first: high high low low low high high
    localparam logic [SLOTS-1:0] FWD_CLK_PATTERN = 7'h63;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ      = 50;  // Pixel clock rate of this build
    localparam int PLL_LOCK_WAIT_MS = 10;  // Lock time after clock start
    // Longest wait rounds down; 10 ms at 50 MHz is 500000 cycles
    localparam int PLL_LOCK_WAIT_CYC =
        PLL_LOCK_WAIT_MS * 1000 * SYS_CLK_MHZ;
    localparam int LOCK_CNT_W = 20;        // Holds the lock count

    // ------------------------------------------------------------------
    // Pixel-side sequencing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DLS_OFF,        // Powered down, link idle
        DLS_LOCK_WAIT,  // Waiting for the lane clock to settle
        DLS_RUN         // Words are handed to the link
    } dls_state_t;

endpackage : dls_pkg

/* File: core/dls_sync.sv */
// Three-stage synchroniser with a filtered output flop that accepts a change once two stages agree
`timescale 1ns/100ps
module dls_sync
    import dls_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [0:0] RST_VAL = 1'h0
)
(
    // Clock and reset of the receiving domain
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    // Foreign level in, filtered level out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [W-1:0] s1_reg;   // Metastable stage, read only by s2
    logic [W-1:0] s2_reg;   // Second stage
    logic [W-1:0] s3_reg;   // Third stage
    logic [W-1:0] q_reg;    // Accepted value
    logic [W-1:0] q_next;

    // Accept a bit only when stages two and three agree
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
        end
    end

    // Shift chain and filtered output
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s1_reg <= {W{RST_VAL}};
            s2_reg <= {W{RST_VAL}};
            s3_reg <= {W{RST_VAL}};
            q_reg  <= {W{RST_VAL}};
        end
        else
        begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg  <= q_next;
        end
    end

    assign q_out = q_reg;

endmodule : dls_sync

/* File: core/dls_lane_ser.sv */
// One seven-slot lane shifter with registered output
`timescale 1ns/100ps
module dls_lane_ser
    import dls_pkg::*;
(
    // Lane clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    // Parallel slot bits, loaded at a period start
    input  wire logic             load_in,
    input  wire logic [SLOTS-1:0] slots_in,
    // Forces the line low while the driver is off
    input  wire logic             enable_in,
    // Serial bit
    output logic                  bit_out
);

    // ------------------------------------------------------------------
    // Shift state
    // ------------------------------------------------------------------
    logic [SLOTS-2:0] shift_reg;   // Slots still to go
    logic [SLOTS-2:0] shift_next;
    logic             bit_reg;     // Bit on the line now
    logic             bit_next;

    // Slot 0 leaves first so the period starts with bit 0
    always_comb
    begin
        if (load_in)
        begin
            bit_next   = slots_in[0];
            shift_next = slots_in[SLOTS-1:1];
        end
        else
        begin
            bit_next   = shift_reg[0];
            shift_next = {1'h0, shift_reg[SLOTS-2:1]};
        end
        // A quiet line while disabled avoids stray edges at re-enable
        if (!enable_in)
        begin
            bit_next = 1'h0;
        end
    end

    // Register the line bit
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            shift_reg <= '0;
            bit_reg   <= 1'h0;
        end
        else
        begin
            shift_reg <= shift_next;
            bit_reg   <= bit_next;
        end
    end

    assign bit_out = bit_reg;

endmodule : dls_lane_ser

/* File: verif/dls_serializer_monitor.sv */
// Port-level assertion checker for the display link serializer
`timescale 1ns/100ps
module dls_serializer_monitor
    import dls_pkg::*;
#(
    parameter int LANES            = WIDE_LANES,
    parameter int LOCK_WAIT_CYCLES = 20
)
(
    // Clocks and reset
    input wire logic             clk_sys_in,
    input wire logic             nrst_in,
    input wire logic             bit_clk_in,
    // Static pin
    input wire logic             power_down_n_in,
    // Lanes and status
    input wire logic [LANES-1:0] serial_data_lane_out,
    input wire logic [LANES-1:0] serial_data_lane_oe_out,
    input wire logic             forwarded_lane_clock_out,
    input wire logic             forwarded_lane_clock_oe_out,
    input wire logic             link_ready_out
);
    // ------------------------------------------------------------
    // Powered-up pixel cycle count, saturating so it never wraps
    // ------------------------------------------------------------
    int up_cnt_reg;  // Cycles since power-up
    int up_cnt_next; // Next count
    always_comb
    begin
        up_cnt_next = up_cnt_reg;
        if (!power_down_n_in)
            up_cnt_next = 0;
        else if (up_cnt_reg < LOCK_WAIT_CYCLES + 16)
            up_cnt_next = up_cnt_reg + 1;
    end
    // Register only
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            up_cnt_reg <= 0;
        else
            up_cnt_reg <= up_cnt_next;
    end
    // ------------------------------------------------------------
    // Forwarded clock shape from the falling edge at slot 2
    // ------------------------------------------------------------
    sequence fwd_fall_s;
        forwarded_lane_clock_oe_out && $fell(forwarded_lane_clock_out);
    endsequence
    sequence fwd_tail_s;
        (!forwarded_lane_clock_out)[*2] ##1 forwarded_lane_clock_out[*4]
            ##1 !forwarded_lane_clock_out;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    fwd_shape_a: assert property (@(posedge bit_clk_in)
        disable iff (!nrst_in || !power_down_n_in) fwd_fall_s |=> fwd_tail_s)
        else $error("forwarded clock pattern broken");
    pd_off_a: assert property (@(posedge bit_clk_in)
        disable iff (!nrst_in) $fell(power_down_n_in)
        |-> ##[1:16] !forwarded_lane_clock_oe_out)
        else $error("drivers still on after power down");
    pd_held_a: assert property (@(posedge bit_clk_in)
        disable iff (!nrst_in)
        (!power_down_n_in)[*8] |-> serial_data_lane_oe_out == '0)
        else $error("lane driver on during power down");
    lanes_quiet_a: assert property (@(posedge bit_clk_in)
        disable iff (!nrst_in) (!forwarded_lane_clock_oe_out)[*2]
        |-> serial_data_lane_out == '0 && !forwarded_lane_clock_out)
        else $error("disabled lane not quiet");
    oe_match_a: assert property (@(posedge bit_clk_in)
        disable iff (!nrst_in)
        serial_data_lane_oe_out == {LANES{forwarded_lane_clock_oe_out}})
        else $error("clock lane enable differs from data lanes");
    lock_early_a: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        $rose(link_ready_out) |-> up_cnt_reg >= LOCK_WAIT_CYCLES)
        else $error("link ready before lock wait");
    lock_late_a: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        up_cnt_reg == LOCK_WAIT_CYCLES + 10 |-> link_ready_out)
        else $error("link ready late");
    ready_drop_a: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        $fell(power_down_n_in) |-> ##[1:6] !link_ready_out)
        else $error("link ready kept in power down");
endmodule : dls_serializer_monitor

bind dls_serializer_top dls_serializer_monitor #(
    .LANES(LANES),
    .LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)
) u_mon (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .bit_clk_in(bit_clk_in),
    .power_down_n_in(power_down_n_in),
    .serial_data_lane_out(serial_data_lane_out),
    .serial_data_lane_oe_out(serial_data_lane_oe_out),
    .forwarded_lane_clock_out(forwarded_lane_clock_out),
    .forwarded_lane_clock_oe_out(forwarded_lane_clock_oe_out),
    .link_ready_out(link_ready_out)
);

/* File: verif/dls_rx_model.sv */
// Far-side deserializing receiver model: rebuilds words from the lanes
`timescale 1ns/100ps
module dls_rx_model
#(
    parameter int LANES = 4
)
(
    // Lane bit clock
    input  wire logic               bit_clk_in,
    // Lanes from the serializer
    input  wire logic [LANES-1:0]   lane_in,
    input  wire logic               fwd_in,
    input  wire logic               fwd_oe_in,
    // Rebuilt word, one-cycle strobe
    output logic                    word_valid_out,
    output logic [7*LANES-1:0]      word_out
);
    logic               prev_fwd; // Last clock lane sample
    int                 slot;     // Slot position, -1 when unlocked
    logic               seen0;    // Slot 0 seen since lock, so the next slot 6 closes a full period
    logic [7*LANES-1:0] acc;      // Word being rebuilt
    initial
    begin
        word_valid_out = 1'b0;
        word_out = '0;
        slot = -1;
        prev_fwd = 1'b0;
        seen0 = 1'b0;
        acc = '0;
    end
    // Falling clock lane marks slot 2; word closes at slot 6
    always @(posedge bit_clk_in)
    begin
        word_valid_out <= 1'b0;
        if (!fwd_oe_in)
        begin
            slot = -1;
            seen0 = 1'b0;
        end
        else
        begin
            if (prev_fwd && !fwd_in)
                slot = 2;
            else if (slot >= 0)
                slot = (slot + 1) % 7;
            if (slot == 0)
                seen0 = 1'b1;
            // Lane n slot k holds word bit 7n+k
            for (int n = 0; n < LANES; n++)
                if (slot >= 0)
                    acc[7*n+slot] = lane_in[n];
            if (slot == 6 && seen0)
            begin
                word_out <= acc;
                word_valid_out <= 1'b1;
            end
        end
        prev_fwd = fwd_in && fwd_oe_in;
    end
endmodule : dls_rx_model

/* File: verif/tb.sv */
// Self-checking bench: random pixel words, both widths, power down
`timescale 1ns/100ps
module tb
    import dls_pkg::*;
;
    localparam int LOCK = 20; // Short lock wait for simulation
    logic clk_sys_in, bit_clk_in, nrst_in, sel, pd_n, hs, vs, de, spare;
    logic [WIDE_COLOR_W-1:0] colour;
    logic [3:0] lw, lw_oe;
    logic [2:0] ln, ln_oe;
    logic fw, fw_oe, fn, fn_oe, rdy_w, rdy_n, vw, vn, drive, chk;
    logic [27:0] ww;
    logic [20:0] wn;
    logic [27:0] qw[$], qn[$]; // Words driven, oldest first
    logic [31:0] x;
    int n_errors, compares, n_rx[2];
    // ------------------------------------------------------------
    // Clocks: 20 ns pixel clock, 6 ns unrelated bit clock
    // ------------------------------------------------------------
    initial begin clk_sys_in = 0; forever #10 clk_sys_in = ~clk_sys_in; end
    initial begin bit_clk_in = 0; #1.3; forever #3 bit_clk_in = ~bit_clk_in; end
    dls_serializer_top #(.LANES(4), .LOCK_WAIT_CYCLES(LOCK)) uut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bit_clk_in(bit_clk_in),
        .colour_in(colour), .line_sync_in(hs), .frame_sync_in(vs),
        .data_valid_enable_in(de), .spare_in(spare),
        .strobe_edge_select_in(sel), .power_down_n_in(pd_n),
        .serial_data_lane_out(lw), .serial_data_lane_oe_out(lw_oe),
        .forwarded_lane_clock_out(fw), .forwarded_lane_clock_oe_out(fw_oe),
        .link_ready_out(rdy_w));
    dls_serializer_top #(.LANES(3), .LOCK_WAIT_CYCLES(LOCK)) uut_n (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bit_clk_in(bit_clk_in),
        .colour_in(colour[NARROW_COLOR_W-1:0]), .line_sync_in(hs),
        .frame_sync_in(vs), .data_valid_enable_in(de), .spare_in(spare),
        .strobe_edge_select_in(sel), .power_down_n_in(pd_n),
        .serial_data_lane_out(ln), .serial_data_lane_oe_out(ln_oe),
        .forwarded_lane_clock_out(fn), .forwarded_lane_clock_oe_out(fn_oe),
        .link_ready_out(rdy_n));
    dls_rx_model #(.LANES(4)) rx_w (.bit_clk_in(bit_clk_in), .lane_in(lw),
        .fwd_in(fw), .fwd_oe_in(fw_oe), .word_valid_out(vw), .word_out(ww));
    dls_rx_model #(.LANES(3)) rx_n (.bit_clk_in(bit_clk_in), .lane_in(ln),
        .fwd_in(fn), .fwd_oe_in(fn_oe), .word_valid_out(vn), .word_out(wn));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    // Words may be skipped but never reordered or altered
    task automatic match_word(ref logic [27:0] q[$], input logic [27:0] w,
                              input int idx);
        while (q.size() > 0 && q[0] !== w)
            void'(q.pop_front());
        check(q.size() > 0, "received word never sent");
        n_rx[idx]++;
    endtask : match_word
    always @(posedge bit_clk_in)
    begin
        if (chk && vw)
            match_word(qw, ww, 0);
        if (chk && vn)
            match_word(qn, {7'h00, wn}, 1);
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // Random words on every falling edge; control bits ride bits 24-26
    always @(negedge clk_sys_in)
    begin
        if (drive)
        begin
            x = xs(x);
            {spare, de, vs, hs, colour} <= x[27:0];
            qw.push_back(x[27:0]);
            qn.push_back({7'h00, x[26:24], x[17:0]});
        end
    end
    task test_done;
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    // Wait for both links, stream words, require deliveries
    task run_traffic;
        for (int i = 0; i < 60 && !(rdy_w && rdy_n); i++)
            @(negedge clk_sys_in);
        check(rdy_w === 1'b1 && rdy_n === 1'b1, "link not ready");
        n_rx = '{0, 0};
        drive = 1;
        // A hand-off round trip is near 100 ns; let stale words drain
        repeat (20) @(negedge clk_sys_in);
        chk = 1;
        repeat (300) @(negedge clk_sys_in);
        check(n_rx[0] > 5 && n_rx[1] > 5, "too few words");
        chk = 0;
    endtask : run_traffic
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        x = 32'h9906;
        {nrst_in, drive, chk, spare, de, vs, hs} = '0;
        colour = '0;
        sel = 1;
        pd_n = 1;
        repeat (5) @(negedge clk_sys_in);
        nrst_in = 1;
        run_traffic();
        for (int e = 0; e < 2; e++)
        begin
            drive = 0;
            pd_n <= 0;
            repeat (5) @(negedge clk_sys_in);
            check({lw_oe, ln_oe, fw_oe, fn_oe} === 9'h000, "oe on");
            check({lw, ln, fw, fn} === 9'h000, "lane active");
            check({rdy_w, rdy_n} === 2'h0, "ready in power down");
            qw.delete();
            qn.delete();
            sel <= e[0];
            repeat (5) @(negedge clk_sys_in);
            pd_n <= 1;
            repeat (10) @(negedge clk_sys_in);
            check({rdy_w, rdy_n} === 2'h0, "ready before lock");
            run_traffic();
        end
        test_done();
    end
    // Whole run is near 1100 pixel clocks
    initial
    begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : tb
